// file: rtl/pbmux_pkg.sv
// Constants and types of the port B multiplexer.
// Assumes one 50 MHz system clock and an eight-pin port.
package pbmux_pkg;

    // Port geometry
    localparam int unsigned PBMUX_PINS        = 8;
    localparam int unsigned PBMUX_SYNC_STAGES = 2;

    // Pin positions of the alternate functions
    localparam int unsigned PBMUX_BIT_SCK    = 7;
    localparam int unsigned PBMUX_BIT_MISO   = 6;
    localparam int unsigned PBMUX_BIT_MOSI   = 5;
    localparam int unsigned PBMUX_BIT_SEL    = 4;
    localparam int unsigned PBMUX_BIT_CMP_B  = 4;
    localparam int unsigned PBMUX_BIT_CMP_A  = 3;
    localparam int unsigned PBMUX_BIT_IRQ2   = 2;
    localparam int unsigned PBMUX_BIT_DIVIDED_CLOCK_OUT   = 1;
    localparam int unsigned PBMUX_BIT_T1     = 1;
    localparam int unsigned PBMUX_BIT_XCK    = 0;
    localparam int unsigned PBMUX_BIT_T0     = 0;

    // Values after reset
    localparam logic [7:0] PBMUX_PIN_OUT_RST = 8'h00;
    localparam logic [7:0] PBMUX_PIN_OE_RST  = 8'h00;
    localparam logic [7:0] PBMUX_PULLUP_RST  = 8'h00;
    localparam logic [7:0] PBMUX_DIE_RST     = 8'h00;
    localparam logic [7:0] PBMUX_INPUT_RST   = 8'h00;
    localparam logic       PBMUX_SEL_N_RST   = 1'b1;
    localparam logic       PBMUX_FLAG_RST    = 1'b0;

    // Per-pin override bundle
    typedef struct packed {
        logic dir_oe;
        logic dir_val;
        logic val_oe;
        logic val_val;
    } pbmux_ovr_t;

    localparam pbmux_ovr_t PBMUX_OVR_NONE = '{dir_oe: 1'b0, dir_val: 1'b0, val_oe: 1'b0, val_val: 1'b0};

endpackage : pbmux_pkg

// file: rtl/pbmux_sync.sv
// Multi-bit level synchroniser, a chain of flip-flops per bit.
// Assumes the inputs are unrelated levels; only the last stage is read outside.
`timescale 1ns/1ns
module pbmux_sync
    import pbmux_pkg::*;
#(
    parameter int unsigned WIDTH  = PBMUX_PINS,
    parameter int unsigned STAGES = PBMUX_SYNC_STAGES
) (
    // Clock and reset
    input  wire logic             i_mclk,
    input  wire logic             i_reset_n,
    input  wire logic             i_clk_en,
    // Data
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] stage_reg [STAGES];

    genvar s;
    generate
        for (s = 0; s < STAGES; s++) begin : g_stage
            always_ff @(posedge i_mclk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    stage_reg[s] <= '0;
                end else if (i_clk_en) begin
                    stage_reg[s] <= (s == 0) ? i_async : stage_reg[(s == 0) ? 0 : s - 1];
                end
            end
        end
    endgenerate

    assign o_sync = stage_reg[STAGES-1];

endmodule : pbmux_sync

// file: rtl/pbmux_pin_cell.sv
// Combinational override cell for one port pin.
// Assumes the caller builds the override bundle.
`timescale 1ns/1ns
module pbmux_pin_cell
    import pbmux_pkg::*;
(
    // Override bundle
    input  wire pbmux_ovr_t i_ovr,
    // Ordinary port register bits
    input  wire logic       i_dir,
    input  wire logic       i_out,
    input  wire logic       i_pullup_disable,
    // Resolved pin controls
    output logic            o_oe,
    output logic            o_val,
    output logic            o_pullup
);

    logic oe_w;

    // RULE17: direction override select
    assign oe_w = i_ovr.dir_oe ? i_ovr.dir_val : i_dir;

    // RULE18: value override select
    assign o_val = (oe_w && i_ovr.val_oe) ? i_ovr.val_val : i_out;

    // RULE7: pull-up on an input whose port output bit is set, unless pull-ups are globally disabled
    assign o_pullup = !oe_w && i_out && !i_pullup_disable;

    assign o_oe = oe_w;

endmodule : pbmux_pin_cell

// file: rtl/pbmux_port_b.sv
// Port B alternate-function multiplexer for SPI, timer, clock and interrupt pins.
// Assumes controls come from the i_mclk domain; pin inputs are asynchronous.
//
// Functional notes
// RULE1: SPI slave forces the clock pin 7 to input.
// RULE2: SPI master leaves pin 7 direction to its direction bit.
// RULE3: Master forces data-in pin 6 to input; slave uses direction bit.
// RULE4: Slave forces data pin 5 to input; master uses direction bit.
// RULE5: Slave forces select pin 4 to input; master uses direction bit.
// RULE6: Slave SPI is active only while select pin is held low.
// RULE7: Forced input pins keep pull-up control from the port output bit.
// RULE8: Timer0 compare B drives pin 4 when its direction bit is output.
// RULE9: Timer0 compare A drives pin 3 when its direction bit is output.
// RULE10: Pin 2 feeds interrupt two; enabling it keeps input enabled.
// RULE11: Clock-out fuse drives divided clock on pin 1, overriding port bits.
// RULE12: Divided clock stays on pin 1 while held in reset.
// RULE13: Pin 0 carries serial sync clock, direction bit picks drive or receive.
// RULE14: Pin 1 feeds timer1 count input, pin 0 feeds timer0.
// RULE15: Pins feed change sources 8..15; bank and mask keep input enabled.
// RULE16: Data pins combine master and slave paths of the SPI.
// RULE17: Direction override enable selects override value over direction bit.
// RULE18: Value override drives override value when driver is enabled.
// RULE19: Unclaimed pins stay under ordinary port register control.
`timescale 1ns/1ns
module pbmux_port_b
    import pbmux_pkg::*;
#(
    parameter int unsigned PINS = PBMUX_PINS
) (
    // Clock, reset and freeze
    input  wire logic            i_mclk,
    input  wire logic            i_reset_n,
    input  wire logic            i_clk_en,
    // Ordinary port registers
    input  wire logic [PINS-1:0] i_port_b_dir,
    input  wire logic [PINS-1:0] i_port_b_out,
    input  wire logic            i_global_pullup_disable,
    // Pads
    input  wire logic [PINS-1:0] i_pin_in,
    output logic      [PINS-1:0] o_pin_out,
    output logic      [PINS-1:0] o_pin_oe,
    output logic      [PINS-1:0] o_pin_pullup,
    output logic      [PINS-1:0] o_digital_input_enable,
    // Sleep state of the processor
    input  wire logic            i_sleep_input_off,
    // SPI controls and paths
    input  wire logic            i_spi_enable_bit,
    input  wire logic            i_spi_master_select,
    input  wire logic            i_spi_sck_drive,
    input  wire logic            i_spi_master_out,
    input  wire logic            i_spi_slave_out,
    output logic                 o_spi_sck_in,
    output logic                 o_spi_master_in,
    output logic                 o_spi_slave_in,
    output logic                 o_spi_slave_select_n,
    output logic                 o_spi_slave_active,
    // Timer 0 compare outputs
    input  wire logic            i_timer0_compare_a_out,
    input  wire logic            i_timer0_compare_a_en,
    input  wire logic            i_timer0_compare_b_out,
    input  wire logic            i_timer0_compare_b_en,
    // Timer count inputs
    output logic                 o_timer0_count_in,
    output logic                 o_timer1_count_in,
    // Divided clock output
    input  wire logic            i_clock_output_fuse,
    input  wire logic            i_divided_clock_out,
    // Serial port synchronous clock
    input  wire logic            i_serial_sync_mode,
    input  wire logic            i_serial_sync_clock_drive,
    output logic                 o_serial_sync_clock,
    // External interrupt two
    input  wire logic            i_external_irq_two_enable,
    output logic                 o_external_irq_two,
    // Pin-change interrupt sources 8 to 15
    input  wire logic            i_pin_change_bank1_enable,
    input  wire logic [PINS-1:0] i_pin_change_mask,
    output logic      [PINS-1:0] o_pin_change_src
);

    // Synchronised pads and mode decode
    logic [PINS-1:0] pin_sync;
    logic            spi_master_on;
    logic            spi_slave_on;
    logic            serial_clk_on;

    // SPI role decode
    assign spi_master_on = i_spi_enable_bit && i_spi_master_select;
    assign spi_slave_on  = i_spi_enable_bit && !i_spi_master_select;
    assign serial_clk_on = i_serial_sync_mode;

    // Pads pass two stages first
    pbmux_sync #(
        .WIDTH  (PINS),
        .STAGES (PBMUX_SYNC_STAGES)
    ) u_sync (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_clk_en  (i_clk_en),
        .i_async   (i_pin_in),
        .o_sync    (pin_sync)
    );

    // Override bundles, one per pin
    pbmux_ovr_t ovr [PINS];

    pbmux_ovr_t ovr_sck;
    pbmux_ovr_t ovr_miso;
    pbmux_ovr_t ovr_mosi;
    pbmux_ovr_t ovr_sel;
    pbmux_ovr_t ovr_cmp_a;
    pbmux_ovr_t ovr_irq2;
    pbmux_ovr_t ovr_divided_clock_out;
    pbmux_ovr_t ovr_xck;

    // RULE1: slave clock pin forced input
    // RULE2: master clock pin follows direction bit
    assign ovr_sck.dir_oe  = spi_slave_on;
    assign ovr_sck.dir_val = 1'b0;
    assign ovr_sck.val_oe  = spi_master_on;
    assign ovr_sck.val_val = i_spi_sck_drive;

    // RULE3: master data-in forced input
    // RULE16: slave output path drives pin 6
    assign ovr_miso.dir_oe  = spi_master_on;
    assign ovr_miso.dir_val = 1'b0;
    assign ovr_miso.val_oe  = spi_slave_on;
    assign ovr_miso.val_val = i_spi_slave_out;

    // RULE4: slave data-in forced input
    // RULE16: master output path drives pin 5
    assign ovr_mosi.dir_oe  = spi_slave_on;
    assign ovr_mosi.dir_val = 1'b0;
    assign ovr_mosi.val_oe  = spi_master_on;
    assign ovr_mosi.val_val = i_spi_master_out;

    // RULE5: slave select forced input
    // RULE8: compare B drives pin 4 if output
    assign ovr_sel.dir_oe  = spi_slave_on;
    assign ovr_sel.dir_val = 1'b0;
    assign ovr_sel.val_oe  = i_timer0_compare_b_en;
    assign ovr_sel.val_val = i_timer0_compare_b_out;

    // RULE9: compare A drives pin 3 if output
    assign ovr_cmp_a.dir_oe  = 1'b0;
    assign ovr_cmp_a.dir_val = 1'b0;
    assign ovr_cmp_a.val_oe  = i_timer0_compare_a_en;
    assign ovr_cmp_a.val_val = i_timer0_compare_a_out;

    // RULE19: pin 2 has no output function
    assign ovr_irq2 = PBMUX_OVR_NONE;

    // RULE11: fuse claims pin 1 as output
    assign ovr_divided_clock_out.dir_oe  = i_clock_output_fuse;
    assign ovr_divided_clock_out.dir_val = 1'b1;
    assign ovr_divided_clock_out.val_oe  = i_clock_output_fuse;
    assign ovr_divided_clock_out.val_val = i_divided_clock_out;

    // RULE13: serial clock driven when direction set
    assign ovr_xck.dir_oe  = 1'b0;
    assign ovr_xck.dir_val = 1'b0;
    assign ovr_xck.val_oe  = serial_clk_on;
    assign ovr_xck.val_val = i_serial_sync_clock_drive;

    assign ovr[PBMUX_BIT_SCK]   = ovr_sck;
    assign ovr[PBMUX_BIT_MISO]  = ovr_miso;
    assign ovr[PBMUX_BIT_MOSI]  = ovr_mosi;
    assign ovr[PBMUX_BIT_SEL]   = ovr_sel;
    assign ovr[PBMUX_BIT_CMP_A] = ovr_cmp_a;
    assign ovr[PBMUX_BIT_IRQ2]  = ovr_irq2;
    assign ovr[PBMUX_BIT_DIVIDED_CLOCK_OUT]  = ovr_divided_clock_out;
    assign ovr[PBMUX_BIT_XCK]   = ovr_xck;

    // Resolved pin controls
    logic [PINS-1:0] pin_oe_w;
    logic [PINS-1:0] pin_val_w;
    logic [PINS-1:0] pin_pullup_w;

    // One cell per pin
    genvar p;
    generate
        for (p = 0; p < PINS; p++) begin : g_pin
            // RULE19: ordinary control when unclaimed
            pbmux_pin_cell u_cell (
                .i_ovr            (ovr[p]),
                .i_dir            (i_port_b_dir[p]),
                .i_out            (i_port_b_out[p]),
                .i_pullup_disable (i_global_pullup_disable),
                .o_oe             (pin_oe_w[p]),
                .o_val            (pin_val_w[p]),
                .o_pullup         (pin_pullup_w[p])
            );
        end
    endgenerate

    // Digital input enable keep-alive terms
    logic [PINS-1:0] die_keep;
    logic [PINS-1:0] die_w;
    logic [PINS-1:0] irq2_keep;

    assign irq2_keep = {{(PINS-1){1'b0}}, i_external_irq_two_enable} << PBMUX_BIT_IRQ2;

    // RULE15: bank and mask keep input on
    // RULE10: interrupt two keeps input on
    assign die_keep = ({PINS{i_pin_change_bank1_enable}} & i_pin_change_mask) | irq2_keep;

    // Asleep: kept inputs only
    assign die_w    = {PINS{!i_sleep_input_off}} | die_keep;

    // Gated digital inputs to the alternate functions
    logic [PINS-1:0] din_w;

    assign din_w = pin_sync & die_w;

    // SPI input paths and select
    logic sck_in_w;
    logic master_in_w;
    logic slave_in_w;
    logic sel_n_w;
    logic slave_active_w;

    assign sck_in_w    = din_w[PBMUX_BIT_SCK];

    // RULE16: master input from pin 6
    assign master_in_w = din_w[PBMUX_BIT_MISO];
    // RULE16: slave input from pin 5
    assign slave_in_w  = din_w[PBMUX_BIT_MOSI];

    // Select reads inactive whenever the SPI is not a slave
    assign sel_n_w     = spi_slave_on ? din_w[PBMUX_BIT_SEL] : 1'b1;

    // RULE6: slave active while select low
    assign slave_active_w = spi_slave_on && !sel_n_w;

    // Counter, serial clock and interrupt inputs
    logic t0_in_w;
    logic t1_in_w;
    logic xck_in_w;
    logic irq2_w;

    // RULE14: timer count inputs from pins 0 and 1
    assign t0_in_w  = din_w[PBMUX_BIT_T0];
    assign t1_in_w  = din_w[PBMUX_BIT_T1];

    // RULE13: serial clock read from pin 0 whenever serial mode is on, driven or not
    assign xck_in_w = serial_clk_on ? din_w[PBMUX_BIT_XCK] : 1'b0;
    // RULE10: interrupt two from pin 2
    assign irq2_w   = din_w[PBMUX_BIT_IRQ2];

    // Output registers
    // Pin 1 clock bypasses these
    logic [PINS-1:0] pin_out_reg;
    logic [PINS-1:0] pin_oe_reg;
    logic [PINS-1:0] pin_pullup_reg;
    logic [PINS-1:0] die_reg;
    logic [PINS-1:0] pin_change_reg;

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pin_out_reg    <= PBMUX_PIN_OUT_RST;
            pin_oe_reg     <= PBMUX_PIN_OE_RST;
            pin_pullup_reg <= PBMUX_PULLUP_RST;
            die_reg        <= PBMUX_DIE_RST;
            pin_change_reg <= PBMUX_INPUT_RST;
        end else if (i_clk_en) begin
            pin_out_reg    <= pin_val_w;
            pin_oe_reg     <= pin_oe_w;
            pin_pullup_reg <= pin_pullup_w;
            die_reg        <= die_w;
            // RULE15: change sources 8..15 in pin order
            pin_change_reg <= din_w;
        end
    end

    // SPI input registers
    logic sck_in_reg;
    logic master_in_reg;
    logic slave_in_reg;
    logic sel_n_reg;
    logic slave_active_reg;

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sck_in_reg       <= PBMUX_FLAG_RST;
            master_in_reg    <= PBMUX_FLAG_RST;
            slave_in_reg     <= PBMUX_FLAG_RST;
            sel_n_reg        <= PBMUX_SEL_N_RST;
            slave_active_reg <= PBMUX_FLAG_RST;
        end else if (i_clk_en) begin
            sck_in_reg       <= sck_in_w;
            master_in_reg    <= master_in_w;
            slave_in_reg     <= slave_in_w;
            sel_n_reg        <= sel_n_w;
            slave_active_reg <= slave_active_w;
        end
    end

    // Counter and interrupt registers
    logic t0_in_reg;
    logic t1_in_reg;
    logic xck_in_reg;
    logic irq2_reg;

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            t0_in_reg  <= PBMUX_FLAG_RST;
            t1_in_reg  <= PBMUX_FLAG_RST;
            xck_in_reg <= PBMUX_FLAG_RST;
            irq2_reg   <= PBMUX_FLAG_RST;
        end else if (i_clk_en) begin
            t0_in_reg  <= t0_in_w;
            t1_in_reg  <= t1_in_w;
            xck_in_reg <= xck_in_w;
            irq2_reg   <= irq2_w;
        end
    end

    // Clock-out pin bypass; a clock cannot pass a flip-flop clocked by itself
    logic [PINS-1:0] divided_clock_out_mask;

    assign divided_clock_out_mask = {{(PINS-1){1'b0}}, i_clock_output_fuse} << PBMUX_BIT_DIVIDED_CLOCK_OUT;

    // RULE12: clock stays on pin during reset
    // RULE11: fuse overrides port bits on pin 1
    assign o_pin_out    = (pin_out_reg & ~divided_clock_out_mask) | ({PINS{i_divided_clock_out}} & divided_clock_out_mask);
    assign o_pin_oe     = pin_oe_reg | divided_clock_out_mask;
    assign o_pin_pullup = pin_pullup_reg & ~divided_clock_out_mask;

    assign o_digital_input_enable = die_reg;
    assign o_pin_change_src       = pin_change_reg;

    assign o_spi_sck_in         = sck_in_reg;
    assign o_spi_master_in      = master_in_reg;
    assign o_spi_slave_in       = slave_in_reg;
    assign o_spi_slave_select_n = sel_n_reg;
    assign o_spi_slave_active   = slave_active_reg;

    assign o_timer0_count_in   = t0_in_reg;
    assign o_timer1_count_in   = t1_in_reg;
    assign o_serial_sync_clock = xck_in_reg;
    assign o_external_irq_two  = irq2_reg;

endmodule : pbmux_port_b

// file: verif/pbmux_port_b_chk.sv
// Assertions for the port B multiplexer, bound below.
// Assumes the one i_mclk domain and sees only the top module's ports.
`timescale 1ns/1ns
module pbmux_port_b_chk
    import pbmux_pkg::*;
#(
    parameter int unsigned PINS = PBMUX_PINS
) (
    // Clock and reset
    input wire logic            i_mclk,
    input wire logic            i_reset_n,
    input wire logic            i_clk_en,
    // Port registers and pads
    input wire logic [PINS-1:0] i_port_b_dir,
    input wire logic [PINS-1:0] i_port_b_out,
    input wire logic            i_global_pullup_disable,
    input wire logic [PINS-1:0] i_pin_in,
    input wire logic [PINS-1:0] o_pin_out,
    input wire logic [PINS-1:0] o_pin_oe,
    input wire logic [PINS-1:0] o_pin_pullup,
    input wire logic [PINS-1:0] o_digital_input_enable,
    // Peripheral controls
    input wire logic            i_spi_enable_bit,
    input wire logic            i_spi_master_select,
    input wire logic            o_spi_slave_active,
    input wire logic            i_timer0_compare_a_out,
    input wire logic            i_timer0_compare_a_en,
    input wire logic            i_timer0_compare_b_out,
    input wire logic            i_timer0_compare_b_en,
    input wire logic            i_clock_output_fuse,
    input wire logic            i_divided_clock_out,
    input wire logic            i_external_irq_two_enable,
    input wire logic            i_pin_change_bank1_enable,
    input wire logic [PINS-1:0] i_pin_change_mask
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    wire logic            slave  = i_spi_enable_bit & ~i_spi_master_select & i_clk_en;
    wire logic            master = i_spi_enable_bit & i_spi_master_select & i_clk_en;
    wire logic [PINS-1:0] keep   = ({PINS{i_pin_change_bank1_enable}} & i_pin_change_mask)
                                 | (PINS'(i_external_irq_two_enable) << PBMUX_BIT_IRQ2);

    sequence s_sel_low;
        (slave & ~i_pin_in[4])[*3];
    endsequence

    property p_sck_slave; slave |=> !o_pin_oe[7]; endproperty
    a_sck_slave: assert property (p_sck_slave) else $error("clock pin driven as slave");
    property p_sck_master; master |=> o_pin_oe[7] == $past(i_port_b_dir[7]); endproperty
    a_sck_master: assert property (p_sck_master) else $error("clock pin ignores dir bit");
    property p_miso_master; master |=> !o_pin_oe[6]; endproperty
    a_miso_master: assert property (p_miso_master) else $error("data-in pin driven as master");
    property p_slave_in; slave |=> o_pin_oe[5:4] == 2'h0; endproperty
    a_slave_in: assert property (p_slave_in) else $error("slave input pins driven");
    property p_sel_active; s_sel_low |=> o_spi_slave_active; endproperty
    a_sel_active: assert property (p_sel_active) else $error("slave not active on low select");
    property p_pu_forced;
        slave |=> o_pin_pullup[7] == ($past(i_port_b_out[7]) & ~$past(i_global_pullup_disable));
    endproperty
    a_pu_forced: assert property (p_pu_forced) else $error("forced pin lost pull-up control");
    property p_cmp_b;
        i_timer0_compare_b_en & i_port_b_dir[4] & ~slave & i_clk_en
            |=> o_pin_oe[4] && o_pin_out[4] == $past(i_timer0_compare_b_out);
    endproperty
    a_cmp_b: assert property (p_cmp_b) else $error("compare B not on pin 4");
    property p_cmp_a;
        i_timer0_compare_a_en & i_port_b_dir[3] & i_clk_en
            |=> o_pin_oe[3] && o_pin_out[3] == $past(i_timer0_compare_a_out);
    endproperty
    a_cmp_a: assert property (p_cmp_a) else $error("compare A not on pin 3");
    property p_clk_out; i_clock_output_fuse |-> o_pin_oe[1] && o_pin_out[1] == i_divided_clock_out; endproperty
    a_clk_out: assert property (p_clk_out) else $error("divided clock missing on pin 1");
    property p_keep_in; i_clk_en |=> (o_digital_input_enable & $past(keep)) == $past(keep); endproperty
    a_keep_in: assert property (p_keep_in) else $error("interrupt pin input disabled");
    property p_plain; i_clk_en |=> o_pin_oe[2] == $past(i_port_b_dir[2]); endproperty
    a_plain: assert property (p_plain) else $error("pin 2 direction not from dir bit");
endmodule : pbmux_port_b_chk

bind pbmux_port_b pbmux_port_b_chk #(.PINS(PINS)) u_chk (.*);

// file: verif/pbmux_pin_model.sv
// Model of the eight external pins: pad driver, far-side drivers, pull-ups.
// Assumes far-side drivers let go of a pin while the pad drives it.
`timescale 1ns/1ns
module pbmux_pin_model (
    // Clock
    input  wire logic       i_mclk,
    // Pad controls
    input  wire logic [7:0] i_pin_out,
    input  wire logic [7:0] i_pin_oe,
    input  wire logic [7:0] i_pin_pullup,
    // Far-side drivers
    input  wire logic [7:0] i_ext_en,
    input  wire logic [7:0] i_ext_val,
    // Pin levels
    output logic      [7:0] o_level
);
    logic [7:0] float_reg = 8'h55;

    // Floating pins wander so no stale level passes for a real one
    always_ff @(posedge i_mclk) begin
        float_reg <= ~float_reg;
    end

    assign o_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_en & i_ext_val)
                   | (~i_pin_oe & ~i_ext_en & (i_pin_pullup | float_reg));
endmodule : pbmux_pin_model

// file: verif/pbmux_port_b_bench.sv
// Self-checking bench for the port B multiplexer.
// Assumes a 50 MHz clock; the checker is bound from its own file.
`timescale 1ns/1ns
module pbmux_port_b_bench;
    logic       i_mclk = 1'b0;
    logic       i_reset_n = 1'b0;
    logic       i_clk_en = 1'b1;
    logic [7:0] i_port_b_dir, i_port_b_out, i_pin_change_mask, ext_val, i_pin_in;
    logic [7:0] o_pin_out, o_pin_oe, o_pin_pullup, o_digital_input_enable, o_pin_change_src;
    logic       i_global_pullup_disable, i_sleep_input_off, i_spi_enable_bit, i_spi_master_select;
    logic       i_spi_sck_drive, i_spi_master_out, i_spi_slave_out, i_clock_output_fuse, i_divided_clock_out;
    logic       i_timer0_compare_a_out, i_timer0_compare_a_en, i_timer0_compare_b_out, i_timer0_compare_b_en;
    logic       i_serial_sync_mode, i_serial_sync_clock_drive, i_external_irq_two_enable, i_pin_change_bank1_enable;
    logic       o_spi_sck_in, o_spi_master_in, o_spi_slave_in, o_spi_slave_select_n, o_spi_slave_active;
    logic       o_timer0_count_in, o_timer1_count_in, o_serial_sync_clock, o_external_irq_two;
    int         fails = 0;
    int         check_count = 0;
    int         cycles = 0;

    pbmux_port_b #(.PINS(8)) DUT (.*);

    pbmux_pin_model u_pins (.i_mclk, .i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe), .i_pin_pullup(o_pin_pullup),
        .i_ext_en(8'hff), .i_ext_val(ext_val), .o_level(i_pin_in));

    always #10 i_mclk = ~i_mclk;

    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 1000) begin
            fails++;
            report_and_stop();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Expected outputs for the current stimulus
    task automatic check_state();
        logic [7:0] oe, ov, pu, die, lv;
        logic       sl, ms;
        sl = i_spi_enable_bit & ~i_spi_master_select;
        ms = i_spi_enable_bit & i_spi_master_select;
        oe = i_port_b_dir;
        ov = i_port_b_out;
        if (sl) begin
            oe = oe & 8'h4f;
            ov[6] = i_spi_slave_out;
        end
        if (ms) begin
            oe[6] = 1'b0;
            ov[7] = i_spi_sck_drive;
            ov[5] = i_spi_master_out;
        end
        if (i_timer0_compare_b_en) ov[4] = i_timer0_compare_b_out;
        if (i_timer0_compare_a_en) ov[3] = i_timer0_compare_a_out;
        if (i_serial_sync_mode) ov[0] = i_serial_sync_clock_drive;
        if (i_clock_output_fuse) begin
            oe[1] = 1'b1;
            ov[1] = i_divided_clock_out;
        end
        pu = ~oe & i_port_b_out & {8{~i_global_pullup_disable}};
        die = {8{~i_sleep_input_off}} | ({8{i_pin_change_bank1_enable}} & i_pin_change_mask)
            | {5'h00, i_external_irq_two_enable, 2'h0};
        lv = ((oe & ov) | (~oe & ext_val)) & die;
        chk("pad enable", oe, o_pin_oe);
        chk("pad value", ov & oe, o_pin_out & o_pin_oe);
        chk("pull-up", pu, o_pin_pullup);
        chk("input enable", die, o_digital_input_enable);
        chk("change sources", lv, o_pin_change_src);
        chk("spi inputs", {5'h00, lv[7:5]}, {5'h00, o_spi_sck_in, o_spi_master_in, o_spi_slave_in});
        chk("select", {6'h00, ~sl | lv[4], sl & ~lv[4]}, {6'h00, o_spi_slave_select_n, o_spi_slave_active});
        chk("count inputs", {6'h00, lv[1:0]}, {6'h00, o_timer1_count_in, o_timer0_count_in});
        chk("serial clock", {7'h00, i_serial_sync_mode & lv[0]}, {7'h00, o_serial_sync_clock});
        chk("irq two", {7'h00, lv[2]}, {7'h00, o_external_irq_two});
    endtask : check_state

    task automatic settle(input string tn);
        repeat (6) @(posedge i_mclk);
        #1;
        check_state();
        $display("Test %s done", tn);
        @(posedge i_mclk);
    endtask : settle

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        {i_port_b_dir, i_port_b_out, i_pin_change_mask, ext_val} = {8'h0f, 8'h5a, 8'h00, 8'ha5};
        {i_global_pullup_disable, i_sleep_input_off, i_spi_enable_bit, i_spi_master_select, i_spi_sck_drive,
         i_spi_master_out, i_spi_slave_out, i_clock_output_fuse, i_divided_clock_out, i_timer0_compare_a_out,
         i_timer0_compare_a_en, i_timer0_compare_b_out, i_timer0_compare_b_en, i_serial_sync_mode,
         i_serial_sync_clock_drive, i_external_irq_two_enable, i_pin_change_bank1_enable} = 17'h00000;
        repeat (4) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        settle("plain port");
        i_global_pullup_disable <= 1'b1;
        settle("pull-ups off");
        {i_global_pullup_disable, i_spi_enable_bit, i_spi_slave_out} <= 3'h3;
        {i_port_b_dir, i_port_b_out, ext_val} <= {8'hff, 8'hff, 8'hef};
        settle("slave selected");
        ext_val <= 8'hff;
        settle("slave deselected");
        {i_spi_master_select, i_spi_sck_drive, i_spi_master_out} <= 3'h7;
        {i_port_b_dir, i_port_b_out} <= {8'h7f, 8'h00};
        settle("master clock in");
        i_port_b_dir <= 8'hff;
        settle("master drive");
        {i_spi_enable_bit, i_timer0_compare_a_en, i_timer0_compare_a_out, i_timer0_compare_b_en} <= 4'h7;
        {i_port_b_dir, i_port_b_out} <= {8'h18, 8'h10};
        settle("compare outputs");
        {i_timer0_compare_a_out, i_timer0_compare_b_out} <= 2'h1;
        settle("compare swap");
        {i_timer0_compare_a_en, i_timer0_compare_b_en, i_clock_output_fuse, i_divided_clock_out} <= 4'h3;
        {i_port_b_dir, i_port_b_out} <= {8'h00, 8'h00};
        settle("clock output");
        i_reset_n <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge i_mclk);
            i_divided_clock_out <= i[0];
            #1;
            chk("clock in reset", {6'h00, 1'b1, i[0]}, {6'h00, o_pin_oe[1], o_pin_out[1]});
        end
        @(posedge i_mclk);
        i_reset_n <= 1'b1;
        {i_clock_output_fuse, i_serial_sync_mode, i_serial_sync_clock_drive} <= 3'h3;
        i_port_b_dir <= 8'h01;
        settle("serial clock drive");
        {i_port_b_dir, ext_val} <= {8'h00, 8'hfe};
        settle("serial clock low");
        ext_val <= 8'h03;
        settle("serial clock high");
        i_serial_sync_mode <= 1'b0;
        settle("serial off");
        {i_sleep_input_off, i_external_irq_two_enable, i_pin_change_bank1_enable} <= 3'h7;
        {i_pin_change_mask, ext_val} <= {8'h81, 8'hff};
        settle("asleep kept");
        {i_external_irq_two_enable, i_pin_change_bank1_enable} <= 2'h0;
        settle("asleep gated");
        report_and_stop();
    end
endmodule : pbmux_port_b_bench
